// [sensor_status_error_regs.sv]
`timescale 1ns/10ps

// What this block does
// RL1 - Index zero returns a fixed identity byte that bus writes never alter.
// RL2 - Index two is the fault report, with every bit zero after reset.
// RL3 - Fault bit 0 marks a dead chip and clears only on reset or soft reset.
// RL4 - Fault bit 1 is set when a host command fails to execute.
// RL5 - Fault bits 4 to 2 follow the error code input one cycle late, 0 none, 1 bad accel config.
// RL6 - Fault bit 6 is set on a stream-mode discard and clears when read.
// RL7 - Fault bit 7 is set on an aux bus master error and clears when read.
// RL8 - Status bit 4 is 1 when a command may be issued, 0 while one runs.
// RL9 - Status bit 2 is 1 while a manual aux transfer is in progress.
// RL10 - Status bit 5 flags new aux data and clears on any aux data read.
// RL11 - Status bit 7 flags new accel data and clears on an accel data read.
// RL12 - Aux X and Y are 16-bit words, low byte even, high byte next; Z has only a low byte; all reset to zero.
module sensor_status_error_regs
   import sensor_regs_pkg::*;
#(
   parameter logic [7:0] PART_IDENTITY_VALUE = IDENTITY_DEFAULT
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // AXI4-Lite write data
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [DATA_W/8-1:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // AXI4-Lite read data
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Events and levels from the sensor core
   input wire fault_events_t fault_ev,
   input wire logic [2:0] config_error_code,
   input wire logic cmd_busy,
   input wire logic aux_manual_transfer_active,
   input wire logic soft_reset,
   // Sample sources
   input wire logic aux_sample_valid,
   input wire aux_sample_t aux_sample,
   input wire logic accel_data_ready,
   input wire logic accel_data_read
);

   // ==========================================================
   // Declarations
   logic awready_q, wready_q, bvalid_q, aw_got_q, w_got_q, aw_hit_q;
   logic arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [DATA_W-1:0] rdata_q;
   logic fatal_q, cmd_err_q, fifo_err_q, aux_err_q;
   logic [2:0] code_q;
   logic cmd_ready_q, man_op_q, drdy_aux_q, drdy_acc_q;
   aux_sample_t aux_q;
   logic [IDX_W-1:0] aw_idx, ar_idx;
   logic rd_take, rd_fault, rd_aux, cmd_start, rd_hit, aw_hit;
   logic [7:0] rd_byte, fault_byte, status_byte;

   assign aw_idx = awaddr[ADDR_W-1:2];
   assign ar_idx = araddr[ADDR_W-1:2];
   assign rd_take = arvalid && arready_q;
   assign rd_fault = rd_take && (ar_idx == IDX_FAULT_REPORT);
   assign rd_aux = rd_take && (ar_idx >= IDX_AUX_X_LOW)
      && (ar_idx <= IDX_AUX_Z_LOW);
   // A command starts when the decoder leaves its ready state
   assign cmd_start = cmd_busy && cmd_ready_q;

   // ==========================================================
   // Register image and address decode
   always_comb begin
      fault_byte = FAULT_RESET;
      fault_byte[FATAL_BIT] = fatal_q;
      fault_byte[CMD_ERR_BIT] = cmd_err_q;
      fault_byte[CODE_MSB:CODE_LSB] = code_q;
      fault_byte[FIFO_ERR_BIT] = fifo_err_q;
      fault_byte[AUX_ERR_BIT] = aux_err_q;
   end

   always_comb begin
      status_byte = 8'h00;
      status_byte[MAN_OP_BIT] = man_op_q;
      status_byte[CMD_RDY_BIT] = cmd_ready_q;
      status_byte[DRDY_AUX_BIT] = drdy_aux_q;
      status_byte[DRDY_ACC_BIT] = drdy_acc_q;
   end

   always_comb begin
      rd_hit = 1'b1;
      unique case (ar_idx)
         IDX_PART_IDENTITY: rd_byte = PART_IDENTITY_VALUE; // RL1
         IDX_FAULT_REPORT: rd_byte = fault_byte; // RL2
         IDX_CONDITION_FLAGS: rd_byte = status_byte;
         IDX_AUX_X_LOW: rd_byte = aux_q.x[7:0]; // RL12
         IDX_AUX_X_HIGH: rd_byte = aux_q.x[15:8]; // RL12
         IDX_AUX_Y_LOW: rd_byte = aux_q.y[7:0];
         IDX_AUX_Y_HIGH: rd_byte = aux_q.y[15:8];
         IDX_AUX_Z_LOW: rd_byte = aux_q.z_low;
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   assign aw_hit = aw_idx inside {IDX_PART_IDENTITY, IDX_FAULT_REPORT,
      IDX_CONDITION_FLAGS, [IDX_AUX_X_LOW:IDX_AUX_Z_LOW]};

   // ==========================================================
   // Write channel: every register is read-only, so a write only
   // earns a response; the payload is dropped on purpose.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         awready_q <= 1'b0;
         aw_got_q <= 1'b0;
         aw_hit_q <= 1'b0;
      end else if (awvalid && awready_q) begin
         awready_q <= 1'b0;
         aw_got_q <= 1'b1;
         aw_hit_q <= aw_hit;
      end else if (aw_got_q && w_got_q && !bvalid_q) begin
         aw_got_q <= 1'b0;
      end else if (!aw_got_q && !awready_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wready_q <= 1'b0;
         w_got_q <= 1'b0;
      end else if (wvalid && wready_q) begin
         wready_q <= 1'b0;
         w_got_q <= 1'b1;
      end else if (aw_got_q && w_got_q && !bvalid_q) begin
         w_got_q <= 1'b0;
      end else if (!w_got_q && !wready_q && !bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (aw_got_q && w_got_q && !bvalid_q) begin
         bvalid_q <= 1'b1; // RL1
         bresp_q <= aw_hit_q ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // Read channel: data is captured at the address handshake, so
   // read side effects happen exactly once per accepted read.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
      end else if (rd_take) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         rdata_q <= {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end else if (!arready_q && !rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   // ==========================================================
   // Fault report
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fatal_q <= 1'b0;
      end else if (soft_reset) begin
         fatal_q <= 1'b0; // RL3
      end else if (fault_ev.fatal) begin
         fatal_q <= 1'b1; // RL3
      end
   end

   // Cleared by the start of the next command; a failure on the
   // same edge still wins.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cmd_err_q <= 1'b0;
      end else if (soft_reset) begin
         cmd_err_q <= 1'b0;
      end else if (fault_ev.cmd_fail) begin
         cmd_err_q <= 1'b1; // RL4
      end else if (cmd_start) begin
         cmd_err_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         code_q <= CODE_NO_ERROR; // RL2
      end else if (soft_reset) begin
         code_q <= CODE_NO_ERROR;
      end else begin
         code_q <= config_error_code; // RL5
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fifo_err_q <= 1'b0;
      end else if (soft_reset) begin
         fifo_err_q <= 1'b0;
      end else if (fault_ev.fifo_discard) begin
         fifo_err_q <= 1'b1; // RL6
      end else if (rd_fault) begin
         fifo_err_q <= 1'b0; // RL6
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         aux_err_q <= 1'b0;
      end else if (soft_reset) begin
         aux_err_q <= 1'b0;
      end else if (fault_ev.aux_bus_error) begin
         aux_err_q <= 1'b1; // RL7
      end else if (rd_fault) begin
         aux_err_q <= 1'b0; // RL7
      end
   end

   // ==========================================================
   // Status flags
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cmd_ready_q <= STATUS_RESET[CMD_RDY_BIT]; // RL8
         man_op_q <= STATUS_RESET[MAN_OP_BIT];
      end else begin
         cmd_ready_q <= !cmd_busy; // RL8
         man_op_q <= aux_manual_transfer_active; // RL9
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         drdy_aux_q <= STATUS_RESET[DRDY_AUX_BIT];
      end else if (soft_reset) begin
         drdy_aux_q <= 1'b0;
      end else if (aux_sample_valid) begin
         drdy_aux_q <= 1'b1; // RL10
      end else if (rd_aux) begin
         drdy_aux_q <= 1'b0; // RL10
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         drdy_acc_q <= STATUS_RESET[DRDY_ACC_BIT];
      end else if (soft_reset) begin
         drdy_acc_q <= 1'b0;
      end else if (accel_data_ready) begin
         drdy_acc_q <= 1'b1; // RL11
      end else if (accel_data_read) begin
         drdy_acc_q <= 1'b0; // RL11
      end
   end

   // ==========================================================
   // Aux sample store; a read racing a new sample may mix bytes of
   // two samples, which the ready flag lets software detect.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         aux_q <= '{x: {DATA_RESET, DATA_RESET},
                    y: {DATA_RESET, DATA_RESET}, z_low: DATA_RESET};
      end else if (soft_reset) begin
         aux_q <= '{x: {DATA_RESET, DATA_RESET},
                    y: {DATA_RESET, DATA_RESET}, z_low: DATA_RESET};
      end else if (aux_sample_valid) begin
         aux_q <= aux_sample; // RL12
      end
   end

   // ==========================================================
   // Outputs
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   identity_read_a: assert property ( // RL1
      rd_take && ar_idx == IDX_PART_IDENTITY
      |=> rvalid && rdata[7:0] == PART_IDENTITY_VALUE)
      else $error("identity read returned wrong value");
   fault_reset_a: assert property ( // RL2
      $rose(resetn) |-> fault_byte == FAULT_RESET)
      else $error("fault report not clear after reset");
   fatal_sticky_a: assert property ( // RL3
      fatal_q && !soft_reset |=> fatal_q)
      else $error("fatal flag dropped without soft reset");
   cmd_err_set_a: assert property ( // RL4
      fault_ev.cmd_fail && !soft_reset |=> cmd_err_q)
      else $error("command failure not flagged");
   code_follow_a: assert property ( // RL5
      !soft_reset |=> code_q == $past(config_error_code))
      else $error("error code not held");
   fifo_flag_a: assert property ( // RL6
      rd_fault && !fault_ev.fifo_discard && !soft_reset
      |=> !fifo_err_q && rdata[FIFO_ERR_BIT] == $past(fifo_err_q))
      else $error("stream discard flag not read-cleared");
   aux_err_flag_a: assert property ( // RL7
      fault_ev.aux_bus_error && !soft_reset |=> aux_err_q [*1]
      ##0 fault_byte[AUX_ERR_BIT])
      else $error("aux bus error not flagged");
   cmd_ready_a: assert property ( // RL8
      cmd_busy ##1 cmd_busy |-> !status_byte[CMD_RDY_BIT])
      else $error("ready shown while command runs");
   man_op_a: assert property ( // RL9
      aux_manual_transfer_active |=> status_byte[MAN_OP_BIT])
      else $error("manual aux transfer not shown");
   drdy_aux_a: assert property ( // RL10
      rd_aux && !aux_sample_valid && !soft_reset |=> !drdy_aux_q)
      else $error("aux ready flag not cleared by data read");
   drdy_acc_a: assert property ( // RL11
      accel_data_ready && !soft_reset |=> drdy_acc_q)
      else $error("accel ready flag not set");
   aux_bytes_a: assert property ( // RL12
      aux_sample_valid && !soft_reset
      |=> {aux_q.x[15:8], aux_q.x[7:0]} == $past(aux_sample.x))
      else $error("aux sample not stored");
   read_latency_a: assert property (
      rd_take |=> rvalid_q && !arready_q)
      else $error("read answer late");
   write_resp_a: assert property (
      aw_got_q && w_got_q && !bvalid_q |=> bvalid_q ##0
      (bresp_q == (aw_hit_q ? RESP_OKAY : RESP_SLVERR)))
      else $error("write response wrong");

endmodule

// [sensor_regs_pkg.sv]
package sensor_regs_pkg;

   // ==========================================================
   // Bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned IDX_W = 10;
   localparam int unsigned BYTE_W = 8;

   // ==========================================================
   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_PART_IDENTITY = 10'h000;
   localparam logic [IDX_W-1:0] IDX_FAULT_REPORT = 10'h002;
   localparam logic [IDX_W-1:0] IDX_CONDITION_FLAGS = 10'h003;
   localparam logic [IDX_W-1:0] IDX_AUX_X_LOW = 10'h00a;
   localparam logic [IDX_W-1:0] IDX_AUX_X_HIGH = 10'h00b;
   localparam logic [IDX_W-1:0] IDX_AUX_Y_LOW = 10'h00c;
   localparam logic [IDX_W-1:0] IDX_AUX_Y_HIGH = 10'h00d;
   localparam logic [IDX_W-1:0] IDX_AUX_Z_LOW = 10'h00e;

   // ==========================================================
   // Field positions
   localparam int unsigned FATAL_BIT = 0;
   localparam int unsigned CMD_ERR_BIT = 1;
   localparam int unsigned CODE_LSB = 2;
   localparam int unsigned CODE_MSB = 4;
   localparam int unsigned FIFO_ERR_BIT = 6;
   localparam int unsigned AUX_ERR_BIT = 7;
   localparam int unsigned MAN_OP_BIT = 2;
   localparam int unsigned CMD_RDY_BIT = 4;
   localparam int unsigned DRDY_AUX_BIT = 5;
   localparam int unsigned DRDY_ACC_BIT = 7;

   // ==========================================================
   // Codes and reset values
   localparam logic [2:0] CODE_NO_ERROR = 3'h0;
   localparam logic [2:0] CODE_ACCEL_CONFIG = 3'h1;
   localparam logic [7:0] FAULT_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h10;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Arbitrary identity value, not that of any real part
   localparam logic [7:0] IDENTITY_DEFAULT = 8'h5a;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic fatal;
      logic cmd_fail;
      logic fifo_discard;
      logic aux_bus_error;
   } fault_events_t;

   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [7:0] z_low;
   } aux_sample_t;

endpackage

// [host_bus.sv]
`timescale 1ns/10ps

// ==========================================================
// Host side of the register bus: one read and one write at a time
module host_bus
   import sensor_regs_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Write channels
   output logic [ADDR_W-1:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [DATA_W-1:0] wdata,
   output logic [DATA_W/8-1:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read channels
   output logic [ADDR_W-1:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial begin
      awaddr = '0;
      awvalid = 1'b0;
      wdata = '0;
      wstrb = '0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = '0;
      arvalid = 1'b0;
      rready = 1'b0;
   end

   // Released payloads are inverted so a stale value never passes
   task automatic wr(input logic [IDX_W-1:0] idx, output logic [1:0] resp);
      logic aw_p;
      logic w_p;
      @(posedge mclk);
      awaddr <= {idx, 2'b00};
      wdata <= 32'h0000_00a5;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_p = 1'b1;
      w_p = 1'b1;
      while (aw_p || w_p) begin
         @(posedge mclk);
         if (aw_p && awready === 1'b1) begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
            awaddr <= ~{idx, 2'b00};
         end
         if (w_p && wready === 1'b1) begin
            w_p = 1'b0;
            wvalid <= 1'b0;
            wdata <= 32'hffff_ff5a;
         end
      end
      do @(posedge mclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [IDX_W-1:0] idx,
                     output logic [DATA_W-1:0] data, output logic [1:0] resp);
      @(posedge mclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge mclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      araddr <= ~{idx, 2'b00};
      do @(posedge mclk); while (rvalid !== 1'b1);
      data = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
endmodule

// [sensor_status_error_regs_tb_top.sv]
`timescale 1ns/10ps

module sensor_status_error_regs_tb_top;
   import sensor_regs_pkg::*;
   // Arbitrary identity value for this bench
   localparam logic [7:0] ID_VAL = 8'h3c;
   logic mclk;
   logic resetn;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [DATA_W-1:0] wdata, rdata;
   logic [DATA_W/8-1:0] wstrb;
   logic [1:0] bresp, rresp;
   fault_events_t fault_ev;
   logic [2:0] config_error_code;
   logic cmd_busy, aux_manual_transfer_active, soft_reset;
   logic aux_sample_valid, accel_data_ready, accel_data_read;
   aux_sample_t aux_sample;
   int mismatches = 0;
   int tests_run = 0;

   sensor_status_error_regs #(.PART_IDENTITY_VALUE(ID_VAL))
         u_sensor_status_error_regs (
      .mclk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .fault_ev, .config_error_code, .cmd_busy,
      .aux_manual_transfer_active, .soft_reset, .aux_sample_valid,
      .aux_sample, .accel_data_ready, .accel_data_read);

   host_bus u_host_bus (
      .mclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready);

   // ==========================================================
   // Helpers
   task automatic finish_test;
      $display("Checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rc(input string what, input logic [IDX_W-1:0] idx,
                     input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      u_host_bus.rd(idx, d, r);
      chk({what, " data"}, d, {24'h0, exp});
      chk({what, " resp"}, {30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   // One-cycle core events; all pulse inputs drop together afterwards
   task automatic pulse(input fault_events_t f, input logic sr, av, ar, ad);
      @(posedge mclk);
      fault_ev <= f;
      soft_reset <= sr;
      aux_sample_valid <= av;
      accel_data_ready <= ar;
      accel_data_read <= ad;
      @(posedge mclk);
      fault_ev <= '0;
      soft_reset <= 1'b0;
      aux_sample_valid <= 1'b0;
      accel_data_ready <= 1'b0;
      accel_data_read <= 1'b0;
   endtask

   // ==========================================================
   // Clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Little more than a hundred cycles are expected; this bound is generous
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      $display("ERROR watchdog expected done seen hang");
      finish_test();
   end

   // ==========================================================
   // Tests
   initial begin : main
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] aux_exp [4];
      aux_exp = '{8'h12, 8'h78, 8'h56, 8'h9a};
      resetn = 1'b0;
      fault_ev = '0;
      config_error_code = CODE_NO_ERROR;
      cmd_busy = 1'b0;
      aux_manual_transfer_active = 1'b0;
      soft_reset = 1'b0;
      aux_sample_valid = 1'b0;
      aux_sample = '0;
      accel_data_ready = 1'b0;
      accel_data_read = 1'b0;
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;

      rc("identity", IDX_PART_IDENTITY, ID_VAL);
      rc("fault reset", IDX_FAULT_REPORT, FAULT_RESET);
      rc("status reset", IDX_CONDITION_FLAGS, STATUS_RESET);
      for (int i = 0; i < 5; i++) begin
         rc("aux reset", IDX_AUX_X_LOW + 10'(i), DATA_RESET);
      end
      $display("Test reset values done");

      u_host_bus.wr(IDX_PART_IDENTITY, r);
      chk("identity write resp", {30'h0, r}, {30'h0, RESP_OKAY});
      rc("identity kept", IDX_PART_IDENTITY, ID_VAL);
      u_host_bus.wr(10'h005, r);
      chk("unmapped write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      u_host_bus.rd(10'h005, d, r);
      chk("unmapped read resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      chk("unmapped read data", d, 32'h0);
      $display("Test writes done");

      @(posedge mclk);
      config_error_code <= CODE_ACCEL_CONFIG;
      pulse(4'hf, 1'b0, 1'b0, 1'b0, 1'b0);
      rc("fault all", IDX_FAULT_REPORT, 8'hc7);
      rc("fault reread", IDX_FAULT_REPORT, 8'h07);
      @(posedge mclk);
      config_error_code <= CODE_NO_ERROR;
      rc("fault no code", IDX_FAULT_REPORT, 8'h03);
      pulse('0, 1'b1, 1'b0, 1'b0, 1'b0);
      rc("fault soft reset", IDX_FAULT_REPORT, 8'h00);
      $display("Test fault report done");

      @(posedge mclk);
      cmd_busy <= 1'b1;
      aux_manual_transfer_active <= 1'b1;
      rc("status busy", IDX_CONDITION_FLAGS, 8'h04);
      @(posedge mclk);
      cmd_busy <= 1'b0;
      aux_manual_transfer_active <= 1'b0;
      rc("status idle", IDX_CONDITION_FLAGS, STATUS_RESET);
      $display("Test status levels done");

      @(posedge mclk);
      aux_sample <= 40'h1234_5678_9a;
      pulse('0, 1'b0, 1'b1, 1'b0, 1'b0);
      aux_sample <= '0;
      rc("status aux new", IDX_CONDITION_FLAGS, 8'h30);
      rc("aux x low", IDX_AUX_X_LOW, 8'h34);
      rc("status aux read", IDX_CONDITION_FLAGS, 8'h10);
      for (int i = 0; i < 4; i++) begin
         rc("aux bytes", IDX_AUX_X_HIGH + 10'(i), aux_exp[i]);
      end
      pulse('0, 1'b0, 1'b1, 1'b0, 1'b0);
      rc("aux z low", IDX_AUX_Z_LOW, 8'h00);
      rc("status aux z read", IDX_CONDITION_FLAGS, 8'h10);
      $display("Test aux data done");

      pulse('0, 1'b0, 1'b0, 1'b1, 1'b0);
      rc("status accel new", IDX_CONDITION_FLAGS, 8'h90);
      pulse('0, 1'b0, 1'b0, 1'b0, 1'b1);
      rc("status accel read", IDX_CONDITION_FLAGS, 8'h10);
      $display("Test accel ready done");

      finish_test();
   end
endmodule
